/* hw/rft_params.svh */
// Register map, reset values, field positions and timing constants of the frame timer
`ifndef RFT_PARAMS_SVH
`define RFT_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RFT_ADDR_CLOCK 8'h2a
`define RFT_ADDR_CONTROL 8'h2b
`define RFT_ADDR_RELOAD 8'h2c
`define RFT_ADDR_STATUS 8'h2d
`define RFT_ADDR_MASK 8'h2e
`define RFT_ADDR_COUNT 8'h2f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RFT_RST_CLOCK 8'h07
`define RFT_RST_CONTROL 8'h06
`define RFT_RST_RELOAD 8'h0a
`define RFT_RST_MASK 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RFT_BIT_AUTO 5
`define RFT_EXP_HI 4
`define RFT_EXP_LO 0
`define RFT_BIT_HALT_DONE 3
`define RFT_BIT_HALT_FIRST 2
`define RFT_BIT_RUN_DONE 1
`define RFT_BIT_RUN_FIRST 0
`define RFT_BIT_EXPIRED 0
`define RFT_EXP_MAX 5'h15

// ----------------------------------------
// Reference clock
// ----------------------------------------
`define RFT_REF_KHZ 13560

`endif

/* hw/rft_pkg.sv */
// Types shared by the frame timer modules
package rft_pkg;
   typedef logic [7:0] rft_byte_type;
   typedef logic [4:0] rft_exp_type;
   typedef enum logic {RFT_IDLE, RFT_RUN} rft_state_type;
endpackage

/* hw/rft_tick_if.sv */
// Interface between the countdown core and its prescaler
`timescale 1ns/1ps
interface rft_tick_if;
   import rft_pkg::*;
   rft_exp_type exponent;
   logic restart;
   logic tick;
   modport core (output exponent, output restart, input tick);
   modport gen (input exponent, input restart, output tick);
endinterface

/* hw/rft_prescaler.sv */
// Power-of-two prescaler producing one-cycle timer ticks from the reference enable
`timescale 1ns/1ps
`include "rft_params.svh"
module rft_prescaler #(
   parameter int DIV_WIDTH = 22
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic ref_tick,
   rft_tick_if.gen tk
);
   import rft_pkg::*;

   // Refused at elaboration: a narrower divider cannot reach the largest exponent
   if (DIV_WIDTH <= `RFT_EXP_MAX) begin : g_width_check
      $error("rft_prescaler: DIV_WIDTH must cover exponent 21");
   end

   logic [DIV_WIDTH-1:0] div_reg;
   logic [DIV_WIDTH-1:0] div_next;
   logic [DIV_WIDTH-1:0] mask;

   // Tick after 2**exponent reference edges; exponent 0 passes every edge
   assign mask = (DIV_WIDTH'(1) << tk.exponent) - DIV_WIDTH'(1);
   assign div_next = div_reg + DIV_WIDTH'(1);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         div_reg <= '0;
      end else if (tk.restart) begin
         div_reg <= '0;
      end else if (ref_tick) begin
         div_reg <= div_next & mask;
      end
   end

   assign tk.tick = ref_tick && ((div_reg & mask) == mask);

endmodule

/* hw/rft_frame_timer.sv */
// Frame timer: registers, start/stop logic, countdown and interrupt
`timescale 1ns/1ps
`include "rft_params.svh"

// Summary of operation
// - With auto-reload on, the counter reloads the reload value at zero and keeps running.
// - With auto-reload off, the counter stops at zero and sets the expired flag.
// - The divider exponent is valid from 0 to 21 and every value in that range works.
// - Tick rate is the 13.56 MHz reference divided by two to the exponent.
// - With halt-on-receive-done set, reception end stops the counter, else no effect.
// - With halt-on-first-received-bit set, the first valid bit stops the counter.
// - With run-on-transmit-done set, transmission end starts the counter.
// - With run-on-first-sent-bit set, the first transmitted bit starts the counter.
// - A start while running restarts the count from the reload value.
// - Every start loads the 8-bit reload value as the initial count.
// - Writing the reload register does not disturb a running count.
// - A reload value of zero makes every start event be ignored.
module rft_frame_timer (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic ref_tick,
   input wire logic tx_first_bit,
   input wire logic tx_done,
   input wire logic rx_first_bit,
   input wire logic rx_done,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output logic timer_running,
   output logic irq
);
   import rft_pkg::*;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   rft_byte_type clock_reg;
   rft_byte_type control_reg;
   rft_byte_type reload_reg;
   rft_byte_type mask_reg;
   logic countdown_expired_flag_reg;
   rft_byte_type count_reg;
   rft_state_type state_reg;
   rft_byte_type rdata_reg;

   logic auto_reload_enable;
   rft_exp_type tick_divider_exponent;
   logic halt_on_receive_done;
   logic halt_on_first_received_bit;
   logic run_on_transmit_done;
   logic run_on_first_sent_bit;
   logic start_evt;
   logic stop_evt;
   logic start_ok;
   logic expire_evt;
   logic tick;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign auto_reload_enable = clock_reg[`RFT_BIT_AUTO];
   assign tick_divider_exponent = clock_reg[`RFT_EXP_HI:`RFT_EXP_LO];
   assign halt_on_receive_done = control_reg[`RFT_BIT_HALT_DONE];
   assign halt_on_first_received_bit = control_reg[`RFT_BIT_HALT_FIRST];
   assign run_on_transmit_done = control_reg[`RFT_BIT_RUN_DONE];
   assign run_on_first_sent_bit = control_reg[`RFT_BIT_RUN_FIRST];

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   rft_tick_if tk_if ();
   // Exponents above 21 are clamped so the divider never overruns its width
   assign tk_if.exponent = (tick_divider_exponent > `RFT_EXP_MAX) ? `RFT_EXP_MAX
                           : tick_divider_exponent;
   assign tk_if.restart = start_ok;
   assign tick = tk_if.tick;

   rft_prescaler #(.DIV_WIDTH(22)) u_prescaler (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .ref_tick(ref_tick),
      .tk(tk_if.gen)
   );

   // ----------------------------------------
   // Start and stop events
   // ----------------------------------------
   assign start_evt = (run_on_transmit_done && tx_done)
                      || (run_on_first_sent_bit && tx_first_bit);
   assign stop_evt = (halt_on_receive_done && rx_done)
                     || (halt_on_first_received_bit && rx_first_bit);
   assign start_ok = start_evt && (reload_reg != 8'h00);
   assign expire_evt = (state_reg == RFT_RUN) && tick && (count_reg == 8'h01)
                       && !start_ok && !stop_evt && !auto_reload_enable;

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         clock_reg <= `RFT_RST_CLOCK;
         control_reg <= `RFT_RST_CONTROL;
         reload_reg <= `RFT_RST_RELOAD;
         mask_reg <= `RFT_RST_MASK;
      end else if (reg_write) begin
         if (hit(reg_addr, `RFT_ADDR_CLOCK)) begin
            clock_reg <= reg_wdata;
         end
         if (hit(reg_addr, `RFT_ADDR_CONTROL)) begin
            control_reg <= reg_wdata;
         end
         // Only the register changes; the count picks it up at the next start or auto-reload
         if (hit(reg_addr, `RFT_ADDR_RELOAD)) begin
            reload_reg <= reg_wdata;
         end
         if (hit(reg_addr, `RFT_ADDR_MASK)) begin
            mask_reg <= reg_wdata;
         end
      end
   end

   // ----------------------------------------
   // Countdown
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= RFT_IDLE;
         count_reg <= 8'h00;
      end else begin
         case (state_reg)
            RFT_IDLE: begin
               if (start_ok) begin
                  state_reg <= RFT_RUN;
                  count_reg <= reload_reg;
               end
            end
            RFT_RUN: begin
               // A start beats a stop in the same cycle, so a fresh frame is never lost
               if (start_ok) begin
                  count_reg <= reload_reg;
               end else if (stop_evt) begin
                  state_reg <= RFT_IDLE;
               end else if (tick) begin
                  if (count_reg == 8'h01) begin
                     if (auto_reload_enable) begin
                        count_reg <= reload_reg;
                     end else begin
                        count_reg <= 8'h00;
                        state_reg <= RFT_IDLE;
                     end
                  end else begin
                     count_reg <= count_reg - 8'h01;
                  end
               end
            end
            default: begin
               state_reg <= RFT_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         countdown_expired_flag_reg <= 1'b0;
      end else if (expire_evt) begin
         countdown_expired_flag_reg <= 1'b1;
      end else if (reg_write && hit(reg_addr, `RFT_ADDR_STATUS)
                   && reg_wdata[`RFT_BIT_EXPIRED]) begin
         countdown_expired_flag_reg <= 1'b0;
      end
   end

   assign irq = countdown_expired_flag_reg && mask_reg[`RFT_BIT_EXPIRED];
   assign timer_running = (state_reg == RFT_RUN);

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= 8'h00;
      end else if (reg_read) begin
         if (hit(reg_addr, `RFT_ADDR_CLOCK)) begin
            rdata_reg <= clock_reg;
         end else if (hit(reg_addr, `RFT_ADDR_CONTROL)) begin
            rdata_reg <= control_reg;
         end else if (hit(reg_addr, `RFT_ADDR_RELOAD)) begin
            rdata_reg <= reload_reg;
         end else if (hit(reg_addr, `RFT_ADDR_STATUS)) begin
            rdata_reg <= {7'h00, countdown_expired_flag_reg};
         end else if (hit(reg_addr, `RFT_ADDR_MASK)) begin
            rdata_reg <= mask_reg;
         end else if (hit(reg_addr, `RFT_ADDR_COUNT)) begin
            rdata_reg <= count_reg;
         end else begin
            rdata_reg <= 8'h00;
         end
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign reg_rdata = rdata_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_last_tick;
      state_reg == RFT_RUN && tick && count_reg == 8'h01 && !start_ok && !stop_evt;
   endsequence

   property p_auto_reload;
      @(posedge clk_sys) disable iff (!reset_n)
      (s_last_tick and auto_reload_enable) |=> (count_reg == $past(reload_reg)) && timer_running;
   endproperty
   a_auto_reload: assert property (p_auto_reload) else $error("auto reload failed");

   property p_expire;
      @(posedge clk_sys) disable iff (!reset_n)
      (s_last_tick and !auto_reload_enable) |=> !timer_running && count_reg == 8'h00
         && countdown_expired_flag_reg;
   endproperty
   a_expire: assert property (p_expire) else $error("expiry did not stop and flag");

   property p_exp_range;
      @(posedge clk_sys) disable iff (!reset_n)
      tick_divider_exponent <= `RFT_EXP_MAX |-> tk_if.exponent == tick_divider_exponent;
   endproperty
   a_exp_range: assert property (p_exp_range) else $error("exponent altered");

   property p_tick_needs_ref;
      @(posedge clk_sys) disable iff (!reset_n)
      tick |-> ref_tick;
   endproperty
   a_tick_needs_ref: assert property (p_tick_needs_ref) else $error("tick without reference");

   property p_halt;
      @(posedge clk_sys) disable iff (!reset_n)
      (timer_running && stop_evt && !start_ok) |=> !timer_running && $stable(count_reg);
   endproperty
   a_halt: assert property (p_halt) else $error("stop event ignored");

   property p_halt_first;
      @(posedge clk_sys) disable iff (!reset_n)
      (timer_running && halt_on_first_received_bit && rx_first_bit && !start_ok)
      |=> !timer_running;
   endproperty
   a_halt_first: assert property (p_halt_first) else $error("first bit stop ignored");

   property p_halt_off;
      @(posedge clk_sys) disable iff (!reset_n)
      (timer_running && !halt_on_first_received_bit && !halt_on_receive_done && !tick
       && !start_ok) |=> timer_running;
   endproperty
   a_halt_off: assert property (p_halt_off) else $error("disabled stop acted");

   property p_start;
      @(posedge clk_sys) disable iff (!reset_n)
      start_ok |=> timer_running && count_reg == $past(reload_reg);
   endproperty
   a_start: assert property (p_start) else $error("start did not load");

   // Disabled start sources must leave an idle timer idle
   property p_no_start;
      @(posedge clk_sys) disable iff (!reset_n)
      (!timer_running && !(run_on_transmit_done && tx_done)
       && !(run_on_first_sent_bit && tx_first_bit)) |=> !timer_running;
   endproperty
   a_no_start: assert property (p_no_start) else $error("disabled start acted");

   sequence s_restart;
      timer_running && start_ok;
   endsequence

   property p_restart;
      @(posedge clk_sys) disable iff (!reset_n)
      s_restart |=> timer_running && count_reg == $past(reload_reg);
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not reload");

   property p_zero_reload;
      @(posedge clk_sys) disable iff (!reset_n)
      (!timer_running && reload_reg == 8'h00) |=> !timer_running;
   endproperty
   a_zero_reload: assert property (p_zero_reload) else $error("started with zero reload");

   property p_hold;
      @(posedge clk_sys) disable iff (!reset_n)
      (timer_running && !tick && !start_ok) |=> $stable(count_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved without tick");

   property p_reload_write;
      @(posedge clk_sys) disable iff (!reset_n)
      (timer_running && reg_write && reg_addr == `RFT_ADDR_RELOAD && !start_ok && !tick)
      |=> $stable(count_reg);
   endproperty
   a_reload_write: assert property (p_reload_write) else $error("reload write disturbed count");

   // A clear only wins when no expiry lands in the same cycle
   property p_flag_clear;
      @(posedge clk_sys) disable iff (!reset_n)
      (reg_write && reg_addr == `RFT_ADDR_STATUS && reg_wdata[`RFT_BIT_EXPIRED] && !expire_evt)
      |=> !countdown_expired_flag_reg;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("expired flag not cleared");

endmodule

/* tb/rft_frame_timer_tb.sv */
// Self-checking bench for the frame timer
`timescale 1ns/1ps
`include "rft_params.svh"
module rft_frame_timer_tb;
   logic clk_sys, reset_n, ref_tick, reg_write, reg_read, timer_running, irq;
   logic [3:0] ev;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   int fail_count, compares;

   rft_frame_timer uut (
      .clk_sys(clk_sys), .reset_n(reset_n), .ref_tick(ref_tick),
      .tx_first_bit(ev[0]), .tx_done(ev[1]), .rx_first_bit(ev[2]), .rx_done(ev[3]),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_running(timer_running), .irq(irq)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 chk8(reg_rdata, exp, "register read");
   endtask

   // One-cycle event pulse, then one cycle for the state to follow
   task automatic fire(input int i);
      @(posedge clk_sys);
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev[i] <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask

   // Exactly n reference pulses; ticks are counted from the bench, not from the design
   task automatic refs(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         ref_tick <= 1'b1;
      end
      @(posedge clk_sys);
      ref_tick <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd_chk(8'h2a, 8'h07);
      rd_chk(8'h2b, 8'h06);
      rd_chk(8'h2c, 8'h0a);
      rd_chk(8'h2e, 8'h00);
      rd_chk(8'h2f, 8'h00);
      wr(8'h30, 8'hff);
      rd_chk(8'h30, 8'h00);
   endtask

   task automatic t_zero();
      wr(8'h2b, 8'h02);
      wr(8'h2c, 8'h00);
      fire(1);
      chk1(timer_running, 1'b0, "start with zero reload");
   endtask

   task automatic t_events();
      wr(8'h2c, 8'h20);
      // Fastest ticks, so a count that moved while stopped would show
      wr(8'h2a, 8'h00);
      for (int i = 0; i < 2; i++) begin
         wr(8'h2b, 8'h00);
         fire(i);
         chk1(timer_running, 1'b0, "start disabled");
         wr(8'h2b, 8'h01 << i);
         fire(i);
         chk1(timer_running, 1'b1, "start enabled");
         rd_chk(8'h2f, 8'h20);
         // Stop again so the next source starts from idle
         wr(8'h2b, 8'h08);
         fire(3);
         chk1(timer_running, 1'b0, "stopped between sources");
      end
      for (int i = 2; i < 4; i++) begin
         wr(8'h2b, 8'h01);
         fire(0);
         fire(i);
         chk1(timer_running, 1'b1, "stop disabled");
         wr(8'h2b, 8'h01 | (8'h01 << i));
         fire(i);
         chk1(timer_running, 1'b0, "stop enabled");
      end
      // Stopped count must not move even with ticks arriving
      refs(4);
      rd_chk(8'h2f, 8'h20);
   endtask

   task automatic t_rate();
      wr(8'h2c, 8'h10);
      wr(8'h2b, 8'h01);
      for (int e = 0; e < 4; e++) begin
         wr(8'h2a, e[7:0]);
         fire(0);
         refs((1 << e) - 1);
         rd_chk(8'h2f, 8'h10);
         refs(1);
         rd_chk(8'h2f, 8'h0f);
         refs(1 << e);
         rd_chk(8'h2f, 8'h0e);
      end
      wr(8'h2a, 8'h15);
      rd_chk(8'h2a, 8'h15);
   endtask

   task automatic t_expire();
      wr(8'h2e, 8'h00);
      wr(8'h2a, 8'h00);
      wr(8'h2c, 8'h03);
      fire(0);
      refs(2);
      chk1(timer_running, 1'b1, "one count left");
      refs(1);
      chk1(timer_running, 1'b0, "stopped at zero");
      rd_chk(8'h2f, 8'h00);
      rd_chk(8'h2d, 8'h01);
      chk1(irq, 1'b0, "masked interrupt");
      wr(8'h2e, 8'h01);
      chk1(irq, 1'b1, "unmasked interrupt");
      wr(8'h2d, 8'h01);
      chk1(irq, 1'b0, "cleared interrupt");
      rd_chk(8'h2d, 8'h00);
   endtask

   task automatic t_auto();
      wr(8'h2a, 8'h20);
      wr(8'h2c, 8'h02);
      fire(0);
      refs(2);
      chk1(timer_running, 1'b1, "auto reload keeps running");
      rd_chk(8'h2f, 8'h02);
      refs(1);
      rd_chk(8'h2f, 8'h01);
      rd_chk(8'h2d, 8'h00);
   endtask

   task automatic t_reload();
      wr(8'h2a, 8'h00);
      wr(8'h2c, 8'h40);
      fire(0);
      wr(8'h2c, 8'h30);
      rd_chk(8'h2f, 8'h40);
      refs(1);
      rd_chk(8'h2f, 8'h3f);
      fire(0);
      rd_chk(8'h2f, 8'h30);
   endtask

   // ----------------------------------------
   // Verdict and sequencing
   // ----------------------------------------
   task automatic results();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Whole run is about 310 cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      results();
   end

   initial begin
      fail_count = 0;
      compares = 0;
      reset_n = 1'b0;
      ref_tick = 1'b0;
      ev = 4'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_reset();
      t_zero();
      t_events();
      t_rate();
      t_expire();
      t_auto();
      t_reload();
      results();
   end
endmodule
